//--- core/vpm_pkg.sv
// Constants and carrier types for the virtual partition ID map block
package vpm_pkg;

    // ------------------------------------------------------------
    // Access encoding
    // ------------------------------------------------------------
    localparam logic [1:0] OP0_MAP = 2'h3;
    localparam logic [2:0] OP1_MAP = 3'h4;
    localparam logic [3:0] CRN_MAP = 4'ha;
    localparam logic [3:0] CRM_MAP = 4'h6;
    localparam logic [2:0] OP2_MAP_0_3 = 3'h0;
    localparam logic [2:0] OP2_MAP_4_7 = 3'h1;

    // ------------------------------------------------------------
    // Layout and outcome constants
    // ------------------------------------------------------------
    localparam int ENTRY_W = 16;
    localparam int ENTRIES = 8;
    localparam int REG_W = 64;
    localparam int LANES = REG_W / ENTRY_W;
    localparam logic [2:0] MAX_IDX_NONE = 3'h0;
    localparam logic [11:0] MEM_OFS_0_3 = 12'h940;
    localparam logic [11:0] MEM_OFS_4_7 = 12'h948;
    localparam logic [5:0] TRAP_CLASS = 6'h18;

    // Exception levels
    localparam logic [1:0] LVL_USER = 2'h0;
    localparam logic [1:0] LVL_KERNEL = 2'h1;
    localparam logic [1:0] LVL_HYP = 2'h2;
    localparam logic [1:0] LVL_TOP = 2'h3;

    // Outcome of one register access
    typedef enum logic [2:0] {
        RES_NONE = 3'b000,
        RES_OK = 3'b001,
        RES_UNDEF = 3'b010,
        RES_TRAP_HYP = 3'b011,
        RES_TRAP_TOP = 3'b100,
        RES_MEM = 3'b101
    } vpm_res_type;

    // Access request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] op0;
        logic [2:0] op1;
        logic [3:0] crn;
        logic [3:0] crm;
        logic [2:0] op2;
        logic [63:0] wdata;
    } vpm_req_type;

    // Answer to the core
    typedef struct packed {
        logic done;
        vpm_res_type res;
        logic [5:0] trap_class;
        logic [11:0] mem_ofs;
        logic [63:0] rdata;
    } vpm_rsp_type;

    // Configuration and context levels
    typedef struct packed {
        logic feat_present;
        logic virt_supported_flag;
        logic [2:0] map_reg_max_index;
        logic hyp_enabled;
        logic top_present;
        logic nested_virt_ctrl;
        logic nested_virt_mem_ctrl;
        logic lower_level_trap_bit;
        logic halted;
        logic secure_debug_disable;
        logic kernel_map_enable;
        logic user_map_enable;
        logic guest_follow_bit;
        logic host_kernel_ctrl;
        logic trap_general_ctrl;
        logic [7:0] entry_valid_bits;
        logic [1:0] current_level;
    } vpm_ctx_type;

    // Label lookup result
    typedef struct packed {
        logic [15:0] partition_id;
        logic invalid;
        logic mapped;
    } vpm_lbl_type;

    // Whole module state
    typedef struct packed {
        logic [ENTRIES-1:0][ENTRY_W-1:0] phys_id_entry;
        vpm_rsp_type rsp;
        vpm_lbl_type lbl;
    } vpm_state_type;

endpackage

//--- core/vpm_map.sv
// Virtual partition ID map registers, access checks and label translation
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// Virtual partition ID map
// ------------------------------------------------------------
// Eight 16-bit physical IDs in two 64-bit registers
// Register accesses answered one edge after taken
// Label lookups answered one edge after taken
// Entry contents carry no meaning after reset
// Trap and undefined outcomes never change an entry
// Mapped lookups past implemented entries flagged invalid
// Outputs straight from the state register
// Existence checked before the level ladder
module vpm_map (
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_b_i,
    // Register access and context from the core
    input wire vpm_pkg::vpm_req_type req_i,
    input wire vpm_pkg::vpm_ctx_type ctx_i,
    // Label lookup request
    input wire logic lbl_valid_i,
    input wire logic [15:0] lbl_vid_i,
    // Registered answers
    output var vpm_pkg::vpm_rsp_type rsp_o,
    output var vpm_pkg::vpm_lbl_type lbl_o
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Register index exists under present configuration
    function automatic logic reg_exists(input logic idx, input vpm_pkg::vpm_ctx_type c);
        logic ok;
        ok = c.feat_present & c.virt_supported_flag;
        // second register gated by max index
        if (idx) begin
            ok = ok & (c.map_reg_max_index != vpm_pkg::MAX_IDX_NONE);
        end
        return ok;
    endfunction

    // Trap to top level, or undefined when halted without debug
    function automatic vpm_pkg::vpm_res_type top_trap(input vpm_pkg::vpm_ctx_type c);
        if (c.halted && c.secure_debug_disable) begin
            return vpm_pkg::RES_UNDEF;
        end
        return vpm_pkg::RES_TRAP_TOP;
    endfunction

    // Entry slot addressed by register index and lane
    function automatic logic [2:0] lane_entry(input logic idx, input int lane);
        // low lane holds lowest ID
        // Lane picks the entry inside the register
        return {idx, lane[1:0]};
    endfunction

    // Virtual ID has an implemented entry
    function automatic logic id_in_range(input logic [15:0] vid, input vpm_pkg::vpm_ctx_type c);
        logic ok;
        // Above the second register nothing is implemented
        ok = (vid < 16'(vpm_pkg::ENTRIES));
        // second register absent when max index zero
        if (vid >= 16'(vpm_pkg::LANES)) begin
            ok = ok & (c.map_reg_max_index != vpm_pkg::MAX_IDX_NONE);
        end
        return ok;
    endfunction

    // Outcome is a trap of either kind
    function automatic logic is_trap(input vpm_pkg::vpm_res_type r);
        // Either trap carries the syndrome class
        return (r == vpm_pkg::RES_TRAP_HYP) || (r == vpm_pkg::RES_TRAP_TOP);
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Whole state is one packed struct
    vpm_pkg::vpm_state_type state_q; // Registered state
    vpm_pkg::vpm_state_type state_d; // Next state

    // Access decode terms
    logic hit; // Encoding matches a map register
    logic idx; // Which register
    logic lower_trap; // Lower-level trap active
    vpm_pkg::vpm_res_type res; // Access outcome

    // Lookup terms
    logic use_kernel; // Label drawn from kernel source
    logic map_on; // Mapping applies to this lookup
    logic in_range; // Virtual ID has an implemented entry

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------

    // Access decode, permission checks, lookups
    always_comb begin
        // Hold state; pulse fields drop unless set below
        state_d = state_q;
        state_d.rsp.done = 1'b0;
        state_d.rsp.res = vpm_pkg::RES_NONE;
        state_d.rsp.trap_class = '0;
        state_d.rsp.mem_ofs = '0;
        // Lookup flags stand for one cycle only
        state_d.lbl.mapped = 1'b0;
        state_d.lbl.invalid = 1'b0;

        // --------------------------------------------------------
        // Register access decode
        // --------------------------------------------------------

        hit = (req_i.op0 == vpm_pkg::OP0_MAP) && (req_i.op1 == vpm_pkg::OP1_MAP)
            && (req_i.crn == vpm_pkg::CRN_MAP) && (req_i.crm == vpm_pkg::CRM_MAP)
            && ((req_i.op2 == vpm_pkg::OP2_MAP_0_3) || (req_i.op2 == vpm_pkg::OP2_MAP_4_7));
        // Op2 picks one of the two registers
        idx = (req_i.op2 == vpm_pkg::OP2_MAP_4_7);
        // lower trap needs the top level present
        lower_trap = ctx_i.top_present & ctx_i.lower_level_trap_bit;
        // Safe default for any path left open
        res = vpm_pkg::RES_UNDEF;

        // --------------------------------------------------------
        // Permission ladder by level
        // --------------------------------------------------------

        // absent register undefined at every level
        if (!reg_exists(idx, ctx_i)) begin
            res = vpm_pkg::RES_UNDEF;
        end else begin
            // Present register: outcome by current level
            case (ctx_i.current_level)
                vpm_pkg::LVL_USER: begin
                    res = vpm_pkg::RES_UNDEF;
                end
                // Kernel depends on nested controls
                vpm_pkg::LVL_KERNEL: begin
                    if (ctx_i.hyp_enabled && ctx_i.nested_virt_mem_ctrl
                        && ctx_i.nested_virt_ctrl) begin
                        res = vpm_pkg::RES_MEM;
                    end else if (ctx_i.hyp_enabled && ctx_i.nested_virt_ctrl) begin
                        res = lower_trap ? top_trap(ctx_i) : vpm_pkg::RES_TRAP_HYP;
                    end else begin
                        res = vpm_pkg::RES_UNDEF;
                    end
                end
                vpm_pkg::LVL_HYP: begin
                    res = lower_trap ? top_trap(ctx_i) : vpm_pkg::RES_OK;
                end
                vpm_pkg::LVL_TOP: begin
                    res = vpm_pkg::RES_OK;
                end
                // Unreachable with a two-bit level
                default: begin
                    res = vpm_pkg::RES_UNDEF;
                end
            endcase
        end

        // --------------------------------------------------------
        // Access answer and register update
        // --------------------------------------------------------

        // One answer per decoded access
        if (req_i.valid && hit) begin
            // Done and outcome stand one cycle
            state_d.rsp.done = 1'b1;
            state_d.rsp.res = res;
            if (is_trap(res)) begin
                state_d.rsp.trap_class = vpm_pkg::TRAP_CLASS;
            end
            // memory offset of the addressed register
            if (res == vpm_pkg::RES_MEM) begin
                state_d.rsp.mem_ofs = idx ? vpm_pkg::MEM_OFS_4_7 : vpm_pkg::MEM_OFS_0_3;
            end
            // Refused outcomes leave every entry alone
            if (res == vpm_pkg::RES_OK) begin
                // whole 64-bit access, low ID in low lane
                if (req_i.write) begin
                    // Write all four lanes at once
                    for (int i = 0; i < vpm_pkg::LANES; i++) begin
                        state_d.phys_id_entry[lane_entry(idx, i)] =
                            req_i.wdata[i*vpm_pkg::ENTRY_W +: vpm_pkg::ENTRY_W];
                    end
                end else begin
                    // Read data stands until the next read
                    for (int i = 0; i < vpm_pkg::LANES; i++) begin
                        state_d.rsp.rdata[i*vpm_pkg::ENTRY_W +: vpm_pkg::ENTRY_W] =
                            state_q.phys_id_entry[lane_entry(idx, i)];
                    end
                end
            end
        end

        // --------------------------------------------------------
        // Label source and map enable
        // --------------------------------------------------------

        use_kernel = (ctx_i.current_level == vpm_pkg::LVL_KERNEL)
            || (ctx_i.guest_follow_bit && !ctx_i.trap_general_ctrl);
        if (use_kernel) begin
            // Kernel source follows the kernel enable
            map_on = ctx_i.kernel_map_enable;
        end else begin
            // User source follows the user enable
            map_on = ctx_i.user_map_enable
                && !(ctx_i.host_kernel_ctrl && ctx_i.trap_general_ctrl);
        end
        map_on = map_on && ctx_i.hyp_enabled;
        map_on = map_on && ctx_i.feat_present && ctx_i.virt_supported_flag;
        // Hypervisor and top level labels pass unmapped
        map_on = map_on && (ctx_i.current_level < vpm_pkg::LVL_HYP);
        // entries past the highest register absent
        in_range = id_in_range(lbl_vid_i, ctx_i);

        // --------------------------------------------------------
        // Label translation
        // --------------------------------------------------------

        // Partition ID holds between lookups
        if (lbl_valid_i) begin
            // Unmapped lookups pass the ID through
            state_d.lbl.partition_id = lbl_vid_i;
            if (map_on) begin
                state_d.lbl.mapped = 1'b1;
                if (in_range) begin
                    state_d.lbl.partition_id = state_q.phys_id_entry[lbl_vid_i[2:0]];
                    state_d.lbl.invalid = !ctx_i.entry_valid_bits[lbl_vid_i[2:0]];
                end else begin
                    state_d.lbl.invalid = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // entries reset to zero; software must not rely on it
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        // Asynchronous clear, active low
        if (!rst_b_i) begin
            // Clear all state
            state_q <= '0;
        end else begin
            // Take next state
            state_q <= state_d;
        end
    end

    // Outputs straight from the state register
    assign rsp_o = state_q.rsp;
    assign lbl_o = state_q.lbl;

endmodule // vpm_map
`default_nettype wire

//--- test/vpm_map_chk.sv
// Port assertions for the partition ID map block
`timescale 1ns/1ns
`default_nettype none
module vpm_map_chk (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire vpm_pkg::vpm_req_type req_i,
    input wire vpm_pkg::vpm_ctx_type ctx_i,
    input wire logic lbl_valid_i,
    input wire logic [15:0] lbl_vid_i,
    input wire vpm_pkg::vpm_rsp_type rsp_o,
    input wire vpm_pkg::vpm_lbl_type lbl_o
);
    // Decoded access, and access to a register that exists
    logic hit;
    logic live;
    logic kern;
    assign hit = req_i.valid && req_i.op0 == vpm_pkg::OP0_MAP && req_i.op1 == vpm_pkg::OP1_MAP
        && req_i.crn == vpm_pkg::CRN_MAP && req_i.crm == vpm_pkg::CRM_MAP && req_i.op2[2:1] == 2'h0;
    assign live = hit && ctx_i.feat_present && ctx_i.virt_supported_flag
        && (!req_i.op2[0] || ctx_i.map_reg_max_index != 3'h0);
    assign kern = live && ctx_i.current_level == 2'h1 && ctx_i.hyp_enabled && ctx_i.nested_virt_ctrl;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    answer_a: assert property (hit |=> rsp_o.done)
        else $error("access not answered");
    no_answer_a: assert property (!hit |=> !rsp_o.done)
        else $error("answer without access");
    user_undef_a: assert property (hit && ctx_i.current_level == 2'h0
        |=> rsp_o.res == vpm_pkg::RES_UNDEF) else $error("user access not undefined");
    missing_reg_a: assert property (hit && !live |=> rsp_o.res == vpm_pkg::RES_UNDEF)
        else $error("absent register accessed");
    mem_redirect_a: assert property (kern && ctx_i.nested_virt_mem_ctrl |=>
        rsp_o.res == vpm_pkg::RES_MEM && rsp_o.mem_ofs ==
        ($past(req_i.op2[0]) ? vpm_pkg::MEM_OFS_4_7 : vpm_pkg::MEM_OFS_0_3))
        else $error("bad memory redirect");
    hyp_trap_a: assert property (kern && !ctx_i.nested_virt_mem_ctrl
        && !ctx_i.lower_level_trap_bit |=> rsp_o.res == vpm_pkg::RES_TRAP_HYP
        && rsp_o.trap_class == vpm_pkg::TRAP_CLASS) else $error("bad hypervisor trap");
    top_direct_a: assert property (live && ctx_i.current_level == 2'h3
        |=> rsp_o.res == vpm_pkg::RES_OK) else $error("top level access refused");
    unmapped_id_a: assert property (lbl_valid_i && !ctx_i.hyp_enabled |=>
        lbl_o.partition_id == $past(lbl_vid_i) && !lbl_o.mapped) else $error("id mapped");
endmodule // vpm_map_chk
bind vpm_map vpm_map_chk chk (.clock_i, .rst_b_i, .req_i, .ctx_i, .lbl_valid_i, .lbl_vid_i,
    .rsp_o, .lbl_o);
`default_nettype wire

//--- test/vpm_core_model.sv
// Core-side model: register accesses and label lookups
`timescale 1ns/1ns
`default_nettype none
module vpm_core_model (
    input wire logic clock_i,
    output var vpm_pkg::vpm_req_type req_o,
    output var logic lbl_valid_o,
    output var logic [15:0] lbl_vid_o
);
    initial begin
        req_o = '0;
        lbl_valid_o = 1'b0;
        lbl_vid_o = 16'h0;
    end
    // One access pulse; released data shows its inverse
    task automatic acc(input logic wr, input logic [2:0] op2, input logic [63:0] wd);
        @(posedge clock_i);
        #1;
        req_o = '{1'b1, wr, vpm_pkg::OP0_MAP, vpm_pkg::OP1_MAP, vpm_pkg::CRN_MAP,
            vpm_pkg::CRM_MAP, op2, wd};
        @(posedge clock_i);
        #1;
        req_o.valid = 1'b0;
        req_o.wdata = ~wd;
    endtask
    // One lookup pulse
    task automatic look(input logic [15:0] vid);
        @(posedge clock_i);
        #1;
        lbl_valid_o = 1'b1;
        lbl_vid_o = vid;
        @(posedge clock_i);
        #1;
        lbl_valid_o = 1'b0;
        lbl_vid_o = ~vid;
    endtask
endmodule // vpm_core_model
`default_nettype wire

//--- test/vpm_map_bench.sv
// Self-checking bench for the partition ID map block
`timescale 1ns/1ns
`default_nettype none
module vpm_map_bench;
    logic clock_i;
    logic rst_b_i;
    vpm_pkg::vpm_req_type req;
    vpm_pkg::vpm_ctx_type ctx;
    logic lv;
    logic [15:0] vid;
    vpm_pkg::vpm_rsp_type rsp;
    vpm_pkg::vpm_lbl_type lbl;
    int fail_count = 0;
    int checks = 0;
    // Entries 7..0, ids chosen apart from their index
    logic [127:0] pp = 128'h8e07_6d06_5c05_4b04_3a03_2902_1801_f700;
    // Rows: level, op2, nested, nested mem, lower trap, halted+sdd, outcome
    logic [9:0] rows [10] = '{10'b00_0_0_0_0_0_010, 10'b01_0_1_1_0_0_101,
        10'b01_1_1_1_0_0_101, 10'b01_0_1_0_0_0_011, 10'b01_0_1_0_1_0_100,
        10'b01_0_1_0_1_1_010, 10'b01_0_0_0_0_0_010, 10'b10_0_0_0_1_0_100,
        10'b10_0_0_0_1_1_010, 10'b10_1_0_0_0_0_001};
    vpm_map dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req), .ctx_i(ctx),
        .lbl_valid_i(lv), .lbl_vid_i(vid), .rsp_o(rsp), .lbl_o(lbl));
    vpm_core_model core (.clock_i(clock_i), .req_o(req), .lbl_valid_o(lv), .lbl_vid_o(vid));
    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Access whose refused writes carry inverted data
    task automatic go(input logic wr, input logic [2:0] op2, input logic [2:0] res);
        core.acc(wr, op2, (op2[0] ? pp[127:64] : pp[63:0]) ^ {64{res != 3'h1}});
        chk({rsp.done, rsp.res}, {res != 3'h0, res});
    endtask
    task automatic lk(input logic [15:0] v, input logic [15:0] id, input logic inv, input logic m);
        core.look(v);
        chk({lbl.partition_id, lbl.invalid, lbl.mapped}, {id, inv, m});
    endtask
    initial begin
        #200000;
        fail_count++;
        complete_run();
    end
    initial begin
        rst_b_i = 1'b0;
        ctx = '0;
        ctx.feat_present = 1'b1;
        ctx.virt_supported_flag = 1'b1;
        ctx.map_reg_max_index = 3'h1;
        ctx.hyp_enabled = 1'b1;
        ctx.top_present = 1'b1;
        ctx.entry_valid_bits = 8'h5a;
        ctx.current_level = 2'h3;
        repeat (20) @(posedge clock_i);
        #1 rst_b_i = 1'b1;
        go(1'b1, 3'h0, vpm_pkg::RES_OK);
        go(1'b1, 3'h1, vpm_pkg::RES_OK);
        for (int i = 0; i < 10; i++) begin
            {ctx.current_level, ctx.nested_virt_ctrl, ctx.nested_virt_mem_ctrl} =
                {rows[i][9:8], rows[i][6:5]};
            {ctx.lower_level_trap_bit, ctx.halted, ctx.secure_debug_disable} =
                {rows[i][4], rows[i][3], rows[i][3]};
            go(1'b1, {2'h0, rows[i][7]}, rows[i][2:0]);
            chk(rsp.trap_class, rows[i][2:0] inside {3'h3, 3'h4} ? 6'h18 : 6'h0);
            chk(rsp.mem_ofs, rows[i][2:0] == 3'h5 ? (rows[i][7] ? 12'h948 : 12'h940) : 12'h0);
        end
        ctx.current_level = 2'h3;
        go(1'b0, 3'h0, vpm_pkg::RES_OK);
        chk(rsp.rdata, pp[63:0]);
        go(1'b0, 3'h1, vpm_pkg::RES_OK);
        chk(rsp.rdata, pp[127:64]);
        go(1'b0, 3'h2, vpm_pkg::RES_NONE);
        ctx.map_reg_max_index = 3'h0;
        go(1'b0, 3'h1, vpm_pkg::RES_UNDEF);
        ctx.virt_supported_flag = 1'b0;
        go(1'b0, 3'h0, vpm_pkg::RES_UNDEF);
        ctx.virt_supported_flag = 1'b1;
        ctx.map_reg_max_index = 3'h1;
        ctx.current_level = 2'h1;
        ctx.kernel_map_enable = 1'b1;
        for (int i = 0; i < 8; i++) begin
            lk(16'(i), pp[16*i +: 16], ~ctx.entry_valid_bits[i], 1'b1);
        end
        lk(16'h9, 16'h9, 1'b1, 1'b1);
        ctx.hyp_enabled = 1'b0;
        lk(16'h2, 16'h2, 1'b0, 1'b0);
        ctx.hyp_enabled = 1'b1;
        ctx.kernel_map_enable = 1'b0;
        lk(16'h2, 16'h2, 1'b0, 1'b0);
        ctx.current_level = 2'h0;
        ctx.user_map_enable = 1'b1;
        lk(16'h5, pp[95:80], 1'b1, 1'b1);
        {ctx.host_kernel_ctrl, ctx.trap_general_ctrl} = 2'h3;
        lk(16'h5, 16'h5, 1'b0, 1'b0);
        {ctx.host_kernel_ctrl, ctx.trap_general_ctrl} = 2'h0;
        {ctx.guest_follow_bit, ctx.user_map_enable, ctx.kernel_map_enable} = 3'h5;
        lk(16'h1, pp[31:16], 1'b0, 1'b1);
        ctx.map_reg_max_index = 3'h0;
        lk(16'h5, 16'h5, 1'b1, 1'b1);
        complete_run();
    end
endmodule // vpm_map_bench
`default_nettype wire
